/* File: breaker_model.sv */
// Purpose: breaker contacts and synchro-check stand-in
// Assumes: contacts move DLY+1 clocks after trip or close
// Notes:   slow_i withholds sync release to force a timeout
`timescale 1ns/1ps
module breaker_model #(
    parameter int DLY = 8
) (
    input  wire logic clk_i,
    input  wire logic trip_i,
    input  wire logic close_i,
    input  wire logic slow_i,
    output logic      open_o,
    output logic      ready_o,
    output logic      sync_o
);
    int cnt = 0;
    initial open_o = 1'b0;
    assign ready_o = 1'b1;
    assign sync_o = !slow_i;
    always @(posedge clk_i) begin
        cnt <= ((trip_i && !open_o) || (close_i && open_o)) ? cnt + 1 : 0;
        if (cnt == DLY) begin
            open_o <= !open_o;
        end
    end
endmodule : breaker_model

/* File: reclose_pkg.sv */
// Purpose: shared constants and types of the reclosing sequencer
// Assumes: 40 MHz system clock, timer settings held in milliseconds
// Notes:   timer settings are indexed by the T_* constants below
package reclose_pkg;
    localparam int unsigned CLK_HZ   = 40000000;
    localparam int unsigned TICK_MS  = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TW       = 17;
    localparam int unsigned NTMR     = 19;

    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_TMR0   = 8'h40;
    localparam logic [7:0] ADR_TMRN   = 8'h88;
    localparam logic [31:0] CTRL_RST  = 32'h00000003;

    localparam int unsigned T_SPDT  = 0;
    localparam int unsigned T_MPDT  = 4;
    localparam int unsigned T_SPEC  = 8;
    localparam int unsigned T_RECL  = 9;
    localparam int unsigned T_CLOSE = 10;
    localparam int unsigned T_DYN   = 11;
    localparam int unsigned T_MAN   = 12;
    localparam int unsigned T_ACT   = 13;
    localparam int unsigned T_STL   = 14;
    localparam int unsigned T_DTD   = 15;
    localparam int unsigned T_CBR   = 16;
    localparam int unsigned T_SYN1  = 17;
    localparam int unsigned T_SYN2  = 18;

    localparam logic [TW-1:0] TMR_DEF [0:NTMR-1] = '{
        17'h001F4, 17'h00258, 17'h002BC, 17'h00320,
        17'h003E8, 17'h007D0, 17'h00BB8, 17'h00FA0, 17'h00546,
        17'h007D0, 17'h00064, 17'h005DC, 17'h003E8, 17'h003E8,
        17'h003E8, 17'h00BB8, 17'h003E8, 17'h02710, 17'h02710};
    localparam logic [TW-1:0] TMR_MIN [0:NTMR-1] = '{
        17'h00000, 17'h0000A, 17'h0000A, 17'h0000A,
        17'h00000, 17'h0000A, 17'h0000A, 17'h0000A, 17'h00000,
        17'h00064, 17'h0000A, 17'h0000A, 17'h00000, 17'h00000,
        17'h00000, 17'h00000, 17'h0000A, 17'h001F4, 17'h001F4};
    localparam logic [TW-1:0] TMR_MAX [0:NTMR-1] = '{
        17'h186A0, 17'h186A0, 17'h186A0, 17'h186A0,
        17'h186A0, 17'h186A0, 17'h186A0, 17'h186A0, 17'h186A0,
        17'h186A0, 17'h02710, 17'h186A0, 17'h186A0, 17'h04E20,
        17'h02710, 17'h186A0, 17'h186A0, 17'h186A0, 17'h186A0};
    localparam logic [TW-1:0] STEP_MS = 17'h0000A;

    typedef struct packed {
        logic       syncswitch_en;
        logic [4:0] accel_en;
        logic       three_phase_reclose_dis;
        logic       breaker_state_watch_en;
        logic       evolving_fault_sel;
        logic       deadtime_trigger_sel;
        logic [2:0] cycle_count_sel;
        logic       function_enable_sel;
    } ctrl_type;

    typedef struct packed {
        logic block;
        logic start;
        logic trip;
        logic three_phase;
        logic special_first;
        logic breaker_open;
        logic sync_release;
        logic manual_close;
        logic breaker_ready;
        logic deadtime_delay;
        logic sync_switch_done;
    } in_type;

    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_ACTION = 11'h002,
        ST_TRIP   = 11'h004,
        ST_DELAY  = 11'h008,
        ST_DEAD   = 11'h010,
        ST_CBWAIT = 11'h020,
        ST_SYNC   = 11'h040,
        ST_SWITCH = 11'h080,
        ST_CLOSE  = 11'h100,
        ST_RECL   = 11'h200,
        ST_DYN    = 11'h400
    } state_type;
endpackage : reclose_pkg

/* File: reclose_seq.sv */
// Purpose: automatic reclosing sequencer with wishbone settings
// Assumes: all non-wishbone input pins except clk_i and rst_i are asynchronous and pass a three stage synchroniser
// Notes:   one shared sequence timer plus a manual-close block timer
// Behaviour
// - operation on/off, default on; off keeps the function not ready
// - cycle count setting: disabled or one to four cycles, default one
// - dead time starts on trip reset or breaker open, default trip reset
// - evolving fault blocks or continues three-phase, default block
// - timers expire within one percent or thirty milliseconds of setting
// - four single-phase dead times with limits, steps and defaults
// - four multi-phase dead times with limits, steps and defaults
// - special first multi-phase dead time used when its input is set
// - reclaim time 100 to 100000 ms, default 2000 ms
// - close pulse 10 to 10000 ms, default 100 ms
// - dynamic blocking time 10 to 100000 ms, default 1500 ms
// - block after manual close 0 to 100000 ms, default 1000 ms
// - action window after start for the trip, default 1000 ms
// - starting signal length limited, default 1000 ms
// - external dead-time delay bounded, default 3000 ms
// - breaker ready wait bounded, default 1000 ms
// - synchro-check release wait bounded, default 10000 ms
// - synchronous switching wait bounded, default 10000 ms
// - option: open breaker makes the function not ready
// - option: no reclosing after three-phase trips, except an evolving fault continued as three-phase in the dead time
// - four cycle acceleration options and one final trip option
// - dynamic blocked state runs its timer and issues no close
// - one close pulse for all phases, width from its setting
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module reclose_seq #(
    parameter int unsigned TICK_CYCLES = reclose_pkg::TICK_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        block_i,
    input  wire logic        start_i,
    input  wire logic        trip_i,
    input  wire logic        three_phase_trip_i,
    input  wire logic        special_first_dt_in_i,
    input  wire logic        breaker_open_i,
    input  wire logic        sync_release_i,
    input  wire logic        manual_close_i,
    input  wire logic        breaker_ready_i,
    input  wire logic        deadtime_delay_i,
    input  wire logic        sync_switch_done_i,
    output logic             close_pulse_out_o,
    output logic             blocked_o,
    output logic             final_trip_o,
    output logic             accel_o,
    output logic             running_o
);
    localparam int unsigned NIN = $bits(reclose_pkg::in_type);
    localparam int unsigned TW  = reclose_pkg::TW;

    // input synchroniser: change accepted once stages two and three agree
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_ff, s2_ff, s3_ff, in_ff;
    reclose_pkg::in_type in;
    assign raw = {block_i, start_i, trip_i, three_phase_trip_i,
                  special_first_dt_in_i, breaker_open_i, sync_release_i,
                  manual_close_i, breaker_ready_i, deadtime_delay_i,
                  sync_switch_done_i};
    assign in = reclose_pkg::in_type'(in_ff);
    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_ff[g] <= 1'b0;
                    s2_ff[g] <= 1'b0;
                    s3_ff[g] <= 1'b0;
                    in_ff[g] <= 1'b0;
                end else begin
                    s1_ff[g] <= raw[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    if (s2_ff[g] == s3_ff[g]) begin
                        in_ff[g] <= s3_ff[g];
                    end
                end
            end
        end
    endgenerate

    // millisecond tick
    logic [15:0] div_ff, nxt_div;
    logic        tick_ff, nxt_tick;
    always_comb begin
        nxt_div  = div_ff + 16'h0001;
        nxt_tick = 1'b0;
        if (div_ff == 16'(TICK_CYCLES - 1)) begin
            nxt_div  = 16'h0000;
            nxt_tick = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    // wishbone register file
    reclose_pkg::ctrl_type ctrl_ff, nxt_ctrl;
    logic [TW-1:0] tmr_ff [0:reclose_pkg::NTMR-1];
    logic [TW-1:0] nxt_tmr [0:reclose_pkg::NTMR-1];
    logic          ack_ff, nxt_ack;
    logic [31:0]   rd_ff, nxt_rd;
    logic          req, wr;
    logic [7:0]    tidx;
    logic [31:0]   wmask, wval;
    typedef reclose_pkg::state_type state_type;
    localparam state_type ST_IDLE = reclose_pkg::ST_IDLE;
    localparam state_type ST_ACTION = reclose_pkg::ST_ACTION;
    localparam state_type ST_TRIP = reclose_pkg::ST_TRIP;
    localparam state_type ST_DELAY = reclose_pkg::ST_DELAY;
    localparam state_type ST_DEAD = reclose_pkg::ST_DEAD;
    localparam state_type ST_CBWAIT = reclose_pkg::ST_CBWAIT;
    localparam state_type ST_SYNC = reclose_pkg::ST_SYNC;
    localparam state_type ST_SWITCH = reclose_pkg::ST_SWITCH;
    localparam state_type ST_CLOSE = reclose_pkg::ST_CLOSE;
    localparam state_type ST_RECL = reclose_pkg::ST_RECL;
    localparam state_type ST_DYN = reclose_pkg::ST_DYN;
    assign req   = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr    = req & wb_we_i;
    assign tidx  = (wb_adr_i - reclose_pkg::ADR_TMR0) >> 2;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    generate
        for (g = 0; g < reclose_pkg::NTMR; g++) begin : g_tmr
            logic [31:0] merged;
            logic [TW-1:0] snap;
            assign merged = (32'(tmr_ff[g]) & ~wmask) | (wb_dat_i & wmask);
            // settings snap to the 10 ms grid and are clamped to range
            assign snap = TW'(merged[TW-1:0] / reclose_pkg::STEP_MS
                              * reclose_pkg::STEP_MS);
            always_comb begin
                nxt_tmr[g] = tmr_ff[g];
                if (wr && wb_adr_i == reclose_pkg::ADR_TMR0 + 8'(4 * g)) begin
                    if (merged > 32'(reclose_pkg::TMR_MAX[g])) begin
                        nxt_tmr[g] = reclose_pkg::TMR_MAX[g];
                    end else if (snap < reclose_pkg::TMR_MIN[g]) begin
                        nxt_tmr[g] = reclose_pkg::TMR_MIN[g];
                    end else begin
                        nxt_tmr[g] = snap;
                    end
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tmr_ff[g] <= reclose_pkg::TMR_DEF[g];
                end else begin
                    tmr_ff[g] <= nxt_tmr[g];
                end
            end
        end
    endgenerate

    state_type st_ff, nxt_st;
    logic [1:0] cyc_ff, nxt_cyc;
    logic       multi_ff, nxt_multi;
    logic       final_ff, nxt_final;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ack  = req;
        nxt_rd   = 32'h00000000;
        wval     = (32'(ctrl_ff) & ~wmask) | (wb_dat_i & wmask);
        if (wr && wb_adr_i == reclose_pkg::ADR_CTRL) begin
            nxt_ctrl = reclose_pkg::ctrl_type'(wval[$bits(nxt_ctrl)-1:0]);
            if (wval[3:1] > 3'h4) begin
                nxt_ctrl.cycle_count_sel = 3'h4;
            end
        end
        if (req && !wb_we_i) begin
            if (wb_adr_i == reclose_pkg::ADR_CTRL) begin
                nxt_rd = 32'(ctrl_ff);
            end else if (wb_adr_i == reclose_pkg::ADR_STATUS) begin
                nxt_rd = {16'h0000, final_ff, multi_ff, cyc_ff, 1'b0, st_ff};
            end else if (wb_adr_i >= reclose_pkg::ADR_TMR0 &&
                         wb_adr_i <= reclose_pkg::ADR_TMRN &&
                         wb_adr_i[1:0] == 2'h0) begin
                nxt_rd = 32'(tmr_ff[tidx[4:0]]);
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= reclose_pkg::ctrl_type'(reclose_pkg::CTRL_RST);
            ack_ff  <= 1'b0;
            rd_ff   <= 32'h00000000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ack_ff  <= nxt_ack;
            rd_ff   <= nxt_rd;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_ff;

    // manual close block timer
    logic [TW-1:0] mcnt_ff, nxt_mcnt;
    logic          mrun_ff, nxt_mrun;
    always_comb begin
        nxt_mcnt = mcnt_ff;
        nxt_mrun = mrun_ff;
        if (in.manual_close) begin
            nxt_mcnt = '0;
            nxt_mrun = 1'b1;
        end else if (mrun_ff) begin
            if (mcnt_ff >= tmr_ff[reclose_pkg::T_MAN]) begin
                nxt_mrun = 1'b0;
            end else if (tick_ff) begin
                nxt_mcnt = mcnt_ff + 17'h00001;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mcnt_ff <= '0;
            mrun_ff <= 1'b0;
        end else begin
            mcnt_ff <= nxt_mcnt;
            mrun_ff <= nxt_mrun;
        end
    end

    // sequencer
    logic [TW-1:0] cnt_ff, nxt_cnt;
    logic          restart;
    logic          not_ready, last, busy, dead_go;
    logic [TW-1:0] dead_lim;
    logic          close_ff, blk_ff, fin_o_ff, acc_ff, run_ff;
    logic          nxt_acc;

    assign not_ready = !ctrl_ff.function_enable_sel
                     || ctrl_ff.cycle_count_sel == 3'h0
                     || !in.breaker_ready || mrun_ff || in.block
                     || (ctrl_ff.breaker_state_watch_en && in.breaker_open)
                     || (ctrl_ff.deadtime_trigger_sel && in.breaker_open);
    assign last  = 3'(cyc_ff) + 3'h1 >= ctrl_ff.cycle_count_sel;
    assign busy  = st_ff != ST_IDLE && st_ff != ST_DYN;
    // trip reset or breaker open starts the dead time
    assign dead_go = ctrl_ff.deadtime_trigger_sel ? in.breaker_open : !in.trip;
    always_comb begin
        if (!multi_ff) begin
            dead_lim = tmr_ff[reclose_pkg::T_SPDT + 32'(cyc_ff)];
        end else if (cyc_ff == 2'h0 && in.special_first) begin
            dead_lim = tmr_ff[reclose_pkg::T_SPEC];
        end else begin
            dead_lim = tmr_ff[reclose_pkg::T_MPDT + 32'(cyc_ff)];
        end
    end

    always_comb begin
        nxt_st    = st_ff;
        nxt_cyc   = cyc_ff;
        nxt_multi = multi_ff;
        nxt_final = final_ff;
        restart   = 1'b0;
        case (st_ff)
            ST_IDLE: begin
                nxt_final = 1'b0;
                nxt_cyc   = 2'h0;
                if (in.start || in.trip) begin
                    if (mrun_ff || in.block) begin
                        nxt_st = ST_DYN;
                    end else if (!not_ready) begin
                        nxt_st = in.trip ? ST_TRIP : ST_ACTION;
                    end
                end
            end
            ST_ACTION: begin
                if (in.trip) begin
                    nxt_st = ST_TRIP;
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_ACT]) begin
                    nxt_st = ST_DYN;
                end
            end
            ST_TRIP: begin
                nxt_multi = in.three_phase;
                if (in.three_phase && ctrl_ff.three_phase_reclose_dis) begin
                    nxt_st = ST_DYN;
                end else if (in.trip && cnt_ff >= tmr_ff[reclose_pkg::T_STL]) begin
                    nxt_st = ST_DYN;
                end else if (dead_go) begin
                    nxt_st = in.deadtime_delay ? ST_DELAY : ST_DEAD;
                end
            end
            ST_DELAY: begin
                if (!in.deadtime_delay) begin
                    nxt_st = ST_DEAD;
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_DTD]) begin
                    nxt_st = ST_DYN;
                end
            end
            ST_DEAD: begin
                if (in.trip && (multi_ff || !ctrl_ff.evolving_fault_sel)) begin
                    nxt_st    = ST_DYN;
                    nxt_final = 1'b1;
                end else if (in.trip && in.three_phase) begin
                    nxt_multi = 1'b1;
                    restart   = 1'b1;
                end else if (!in.trip && cnt_ff >= dead_lim) begin
                    nxt_st = ST_CBWAIT;
                end
            end
            ST_CBWAIT: begin
                if (in.breaker_ready) begin
                    nxt_st = ST_SYNC;
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_CBR]) begin
                    nxt_st = ST_DYN;
                end
            end
            ST_SYNC: begin
                if (in.sync_release) begin
                    nxt_st = ctrl_ff.syncswitch_en ? ST_SWITCH : ST_CLOSE;
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_SYN1]) begin
                    nxt_st = ST_DYN;
                end
            end
            ST_SWITCH: begin
                if (in.sync_switch_done) begin
                    nxt_st = ST_CLOSE;
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_SYN2]) begin
                    nxt_st = ST_DYN;
                end
            end
            ST_CLOSE: begin
                if (cnt_ff >= tmr_ff[reclose_pkg::T_CLOSE]) begin
                    nxt_st = ST_RECL;
                end
            end
            ST_RECL: begin
                // reclaim counts from the close edge, so a long pulse shortens the time left in it
                if (in.trip) begin
                    if (last) begin
                        nxt_st    = ST_DYN;
                        nxt_final = 1'b1;
                    end else begin
                        nxt_st  = ST_TRIP;
                        nxt_cyc = cyc_ff + 2'h1;
                    end
                end else if (cnt_ff >= tmr_ff[reclose_pkg::T_RECL]) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_DYN: begin
                if (cnt_ff >= tmr_ff[reclose_pkg::T_DYN]) begin
                    nxt_st = ST_IDLE;
                    nxt_final = 1'b0;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        if (busy && (in.manual_close || (ctrl_ff.breaker_state_watch_en
                && in.breaker_open && !in.trip && st_ff == ST_ACTION))) begin
            nxt_st = ST_DYN;
        end
        if (nxt_st != st_ff && nxt_st != ST_RECL) begin
            restart = 1'b1;
        end
        nxt_cnt = cnt_ff;
        if (restart) begin
            nxt_cnt = '0;
        end else if (tick_ff && cnt_ff != '1) begin
            nxt_cnt = cnt_ff + 17'h00001;
        end
    end

    always_comb begin
        nxt_acc = 1'b0;
        if (st_ff == ST_ACTION || st_ff == ST_TRIP) begin
            nxt_acc = cyc_ff == 2'h0 && ctrl_ff.accel_en[0];
        end else if (st_ff == ST_RECL) begin
            nxt_acc = last ? ctrl_ff.accel_en[4]
                           : ctrl_ff.accel_en[3'(cyc_ff) + 3'h1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff    <= ST_IDLE;
            cyc_ff   <= 2'h0;
            multi_ff <= 1'b0;
            final_ff <= 1'b0;
            cnt_ff   <= '0;
            close_ff <= 1'b0;
            blk_ff   <= 1'b0;
            fin_o_ff <= 1'b0;
            acc_ff   <= 1'b0;
            run_ff   <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            cyc_ff   <= nxt_cyc;
            multi_ff <= nxt_multi;
            final_ff <= nxt_final;
            cnt_ff   <= nxt_cnt;
            close_ff <= nxt_st == ST_CLOSE;
            blk_ff   <= nxt_st == ST_DYN || (nxt_st == ST_IDLE && not_ready);
            fin_o_ff <= nxt_final;
            acc_ff   <= nxt_acc;
            run_ff   <= nxt_st != ST_IDLE && nxt_st != ST_DYN;
        end
    end
    assign close_pulse_out_o = close_ff;
    assign blocked_o         = blk_ff;
    assign final_trip_o      = fin_o_ff;
    assign accel_o           = acc_ff;
    assign running_o         = run_ff;
endmodule : reclose_seq

/* File: reclose_seq_properties.sv */
// Purpose: port-level checks of the reclosing sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   close width upper bound uses a helper counter
`timescale 1ns/1ps
module reclose_seq_properties #(
    parameter int unsigned TICK_CYCLES = 40000
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        close_pulse_out_o,
    input wire logic        blocked_o,
    input wire logic        final_trip_o,
    input wire logic        running_o
);
    logic [31:0] close_cnt_ff;
    logic [31:0] nxt_close_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_close_hold;
        close_pulse_out_o [*8];
    endsequence
    always_comb begin
        nxt_close_cnt = close_pulse_out_o ? close_cnt_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i) begin
        close_cnt_ff <= rst_i ? 32'h0 : nxt_close_cnt;
    end
    a_ack_next: assert property (s_take |=> wb_ack_o) else $error("request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray read data");
    a_close_free: assert property (close_pulse_out_o |-> !blocked_o && running_o)
        else $error("close while blocked or idle");
    a_block_close: assert property (blocked_o |=> !$rose(close_pulse_out_o))
        else $error("close leaves blocked state");
    a_final_block: assert property (final_trip_o |-> blocked_o) else $error("final without block");
    a_close_min: assert property ($rose(close_pulse_out_o) |-> s_close_hold)
        else $error("close pulse too short");
    a_close_max: assert property (close_cnt_ff <= 32'(10001 * TICK_CYCLES))
        else $error("close pulse too long");
endmodule : reclose_seq_properties
bind reclose_seq reclose_seq_properties #(.TICK_CYCLES(TICK_CYCLES)) props (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .close_pulse_out_o, .blocked_o,
    .final_trip_o, .running_o);

/* File: tb.sv */
// Purpose: self-checking bench of the reclosing sequencer
// Assumes: one ms is T clocks; timers are set short
// Notes:   sel stays tied high and four status pins stay tied low
`timescale 1ns/1ps
module tb;
    localparam int T = 4;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
    logic [7:0]          adr = 8'h00;
    logic [31:0]         wd = 32'h0, rd, q;
    logic                ack, close, blk, run, bo, br, bs;
    reclose_pkg::in_type pin = '0;
    int                  failures = 0, tests_run = 0;
    logic [16:0]         def [19] = '{17'h1F4, 17'h258, 17'h2BC, 17'h320, 17'h3E8, 17'h7D0,
        17'hBB8, 17'hFA0, 17'h546, 17'h7D0, 17'h64, 17'h5DC, 17'h3E8, 17'h3E8, 17'h3E8,
        17'hBB8, 17'h3E8, 17'h2710, 17'h2710};
    reclose_seq #(.TICK_CYCLES(T)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .block_i(pin.block), .start_i(pin.start), .trip_i(pin.trip),
        .three_phase_trip_i(pin.three_phase), .special_first_dt_in_i(pin.special_first),
        .breaker_open_i(bo), .sync_release_i(bs), .manual_close_i(pin.manual_close),
        .breaker_ready_i(br), .deadtime_delay_i(pin.deadtime_delay),
        .sync_switch_done_i(pin.sync_switch_done), .close_pulse_out_o(close),
        .blocked_o(blk), .final_trip_o(), .accel_o(), .running_o(run));
    breaker_model model (.clk_i, .trip_i(pin.trip), .close_i(close), .slow_i(slow),
        .open_o(bo), .ready_o(br), .sync_o(bs));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic close_out;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ms(input int n);
        repeat (n * T) @(posedge clk_i);
    endtask : ms
    // waits on the edge-sampled value so a registered answer is seen one edge after it is set
    task automatic await(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v) begin
            @(posedge clk_i);
            n++;
            if (n > lim) begin
                failures++;
                close_out();
            end
        end
    endtask : await
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        await(ack, 1'b1, 50, n);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask : rdchk
    task automatic fault;
        pin.start <= 1'b1;
        ms(2);
        pin.trip <= 1'b1;
        ms(5);
        pin.trip <= 1'b0;
        pin.start <= 1'b0;
    endtask : fault
    task automatic regs;
        rdchk(8'h00, 32'h3);
        for (int i = 0; i < 19; i++) begin
            rdchk(8'h40 + 8'(4 * i), {15'h0, def[i]});
        end
        rdchk(8'h20, 32'h0);
        wb(8'h68, 1'b1, 32'hFFFFF);
        rdchk(8'h68, 32'h2710);
        wb(8'h68, 1'b1, 32'hF);
        rdchk(8'h68, 32'hA);
        wb(8'h64, 1'b1, 32'h0);
        rdchk(8'h64, 32'h64);
    endtask : regs
    task automatic not_ready;
        wb(8'h70, 1'b1, 32'h14);
        pin.manual_close <= 1'b1;
        ms(1);
        pin.manual_close <= 1'b0;
        pin.block <= 1'b1;
        ms(4);
        chk(blk, 1'b1);
        pin.block <= 1'b0;
        ms(20);
        chk(blk, 1'b0);
    endtask : not_ready
    task automatic action;
        wb(8'h74, 1'b1, 32'h14);
        wb(8'h6C, 1'b1, 32'h1E);
        pin.start <= 1'b1;
        ms(18);
        chk(blk, 1'b0);
        ms(6);
        chk(blk, 1'b1);
        pin.start <= 1'b0;
        ms(22);
        chk(blk, 1'b1);
        ms(10);
        chk(blk, 1'b0);
    endtask : action
    task automatic reclose;
        int n;
        wb(8'h40, 1'b1, 32'h14);
        wb(8'h64, 1'b1, 32'h64);
        wb(8'h68, 1'b1, 32'h1E);
        fault();
        await(close, 1'b1, 40 * T, n);
        chk(n >= 20 * T && n <= 24 * T, 1'b1);
        chk(run, 1'b1);
        await(close, 1'b0, 40 * T, n);
        chk(n >= 29 * T && n <= 32 * T, 1'b1);
        ms(60);
        chk(run, 1'b1);
        ms(15);
        chk(run, 1'b0);
    endtask : reclose
    task automatic sync_wait;
        int n;
        wb(8'h84, 1'b1, 32'h0);
        rdchk(8'h84, 32'h1F4);
        slow <= 1'b1;
        fault();
        await(blk, 1'b1, 600 * T, n);
        chk(n >= 518 * T && n <= 526 * T, 1'b1);
        chk(close, 1'b0);
        slow <= 1'b0;
        ms(35);
    endtask : sync_wait
    task automatic op_off;
        wb(8'h00, 1'b1, 32'h0);
        ms(1);
        chk(blk, 1'b1);
        fault();
        ms(2);
        chk(run, 1'b0);
        wb(8'h00, 1'b1, 32'h1);
        ms(1);
        chk(blk, 1'b1);
    endtask : op_off
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        ms(2);
        regs();
        not_ready();
        action();
        reclose();
        sync_wait();
        op_off();
        close_out();
    end
endmodule : tb
